// ---- design/panel_ind_pkg.sv ----
/*
 Constants for the panel status indicator logic: APB register offsets,
 field positions, reset values and timing counts.
 Assumes a 25 MHz system clock and a 32-bit APB master.
*/
package panel_ind_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
   localparam int DEBOUNCE_MS = 20;
   localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int SOUNDER_HALF_MS = 500;
   localparam int SOUNDER_HALF_CYC = CLK_HZ / 1000 * SOUNDER_HALF_MS;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] COND_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] POL_OFS = 8'h08;
   localparam logic [7:0] SWST_OFS = 8'h0c;
   localparam logic [7:0] FUNC_OFS = 8'h10;
   localparam logic [7:0] LED_OFS = 8'h14;
   localparam logic [7:0] ACT_OFS = 8'h18;

   // ----------------------------------------------------------------
   // Condition register fields (levels from the base card)
   // ----------------------------------------------------------------
   localparam int C_ALARM = 0;
   localparam int C_PREALARM = 1;
   localparam int C_DISABLED = 2;
   localparam int C_TEST = 3;
   localparam int C_PAS = 4;
   localparam int C_MAINS = 5;
   localparam int C_SUPV = 6;
   localparam int C_SUPV_LATCH = 7;
   localparam int C_NOTIF_FAULT = 8;
   localparam int C_NOTIF_DIS = 9;
   localparam int C_TROUBLE = 10;
   localparam int C_PROG = 11;
   localparam int COND_W = 12;

   // ----------------------------------------------------------------
   // Command register fields (write one to act)
   // ----------------------------------------------------------------
   localparam int K_ACK = 0;
   localparam int K_RESET = 1;
   localparam int K_SILENCE = 2;
   localparam int K_RESOUND = 3;
   localparam int CMD_W = 4;

   // ----------------------------------------------------------------
   // Indicator output positions
   // ----------------------------------------------------------------
   localparam int L_ALARM = 0;
   localparam int L_PREALARM = 1;
   localparam int L_DISABLE = 2;
   localparam int L_TEST = 3;
   localparam int L_PAS = 4;
   localparam int L_POWER = 5;
   localparam int L_SUPV = 6;
   localparam int L_SILENCED = 7;
   localparam int L_NFAULT = 8;
   localparam int L_NDIS = 9;
   localparam int L_TROUBLE = 10;
   localparam int L_PROG = 11;
   localparam int LED_W = 12;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] POL_RST = 8'hff;
   localparam logic [11:0] FUNC_RST = 12'h000;
   localparam logic [7:0] ACT_RST = 8'h00;

   // Configurable indicator mode per 2-bit field
   typedef enum logic [1:0] {
      FN_OFF = 2'b00,
      FN_ON = 2'b01,
      FN_FLASH = 2'b10,
      FN_SWITCH = 2'b11
   } func_mode_e;

endpackage : panel_ind_pkg

// ---- design/panel_status_indicator_logic.sv ----
/*
 Annunciator logic of the keyboard display: twelve fixed indicators, six
 configurable ones, a local sounder, and eight debounced contact inputs.
 Assumes an APB master on ref_clk_i and raw contact levels on pins.
*/
// Notes on behaviour
// - Eight switch inputs; input eight also fed by a second connector.
// - Per-input polarity: high means closure active, low means opening.
// - Reset leaves every input active-high.
// - An enabled input pulses its action output when it becomes active.
// - Alarm flashes, steady on acknowledge, off only on panel reset.
// - Pre-alarm flashes, steady on ack, clears when condition ends.
// - Disable steady while anything disabled.
// - Test steady while walk test active.
// - Delayed alarm sequence lit while feature in use.
// - Power steady with mains, flashing without.
// - Supervisory flashes, steady on ack, clears unless latching.
// - Silenced lit after silence; cleared by resound or new alarm.
// - Notification fault flashes, sets trouble, steady on ack.
// - Notification disabled steady while any circuit disabled.
// - System trouble flashes, steady on ack, clears when none remain.
// - Programming steady while in programming mode.
// - Six configurable indicators, all dark by default.
// - One acknowledge makes alarm, pre-alarm, supervisory, fault and trouble steady.
// - Sounder continuous for alarms, pulsed for supervisory and trouble.
`timescale 1ns/1ps
`default_nettype none

module panel_status_indicator_logic
   import panel_ind_pkg::*;
#(
   parameter int NUM_SW = 8,
   parameter int NUM_FN = 6,
   parameter int FLASH_CYC = FLASH_HALF_CYC,
   parameter int DEB_CYC = DEBOUNCE_CYC,
   parameter int SND_CYC = SOUNDER_HALF_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Contact inputs
   input wire logic [NUM_SW-1:0] sw_pin_i,
   input wire logic sw8_aux_pin_i,
   // Indicators and sounder
   output logic [LED_W-1:0] led_o,
   output logic [NUM_FN-1:0] func_led_o,
   output logic sounder_o,
   output logic [NUM_SW-1:0] sw_action_o
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic known;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & penable_i & ~pwrite_i;
   assign pready_o = 1'b1;
   assign known = (paddr_i == COND_OFS) | (paddr_i == CMD_OFS) |
                  (paddr_i == POL_OFS) | (paddr_i == SWST_OFS) |
                  (paddr_i == FUNC_OFS) | (paddr_i == LED_OFS) |
                  (paddr_i == ACT_OFS);
   assign pslverr_o = psel_i & penable_i & ~known;

   logic [COND_W-1:0] cond_reg;
   logic [NUM_SW-1:0] pol_reg;
   logic [2*NUM_FN-1:0] func_reg;
   logic [NUM_SW-1:0] act_en_reg;
   logic [CMD_W-1:0] cmd;

   // Commands are one-cycle pulses, never stored
   assign cmd = (wr_en && paddr_i == CMD_OFS) ? pwdata_i[CMD_W-1:0] : '0;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cond_reg <= '0;
      end else if (wr_en && paddr_i == COND_OFS) begin
         cond_reg <= pwdata_i[COND_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pol_reg <= POL_RST;
         func_reg <= FUNC_RST;
         act_en_reg <= ACT_RST;
      end else if (wr_en) begin
         if (paddr_i == POL_OFS) begin
            pol_reg <= pwdata_i[NUM_SW-1:0];
         end
         if (paddr_i == FUNC_OFS) begin
            func_reg <= pwdata_i[2*NUM_FN-1:0];
         end
         if (paddr_i == ACT_OFS) begin
            act_en_reg <= pwdata_i[NUM_SW-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash and sounder timebases
   // ----------------------------------------------------------------
   logic [31:0] flash_cnt_reg;
   logic flash_reg;
   logic [31:0] snd_cnt_reg;
   logic pulse_reg;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         flash_cnt_reg <= '0;
         flash_reg <= 1'b0;
      end else if (flash_cnt_reg == 32'(FLASH_CYC - 1)) begin
         flash_cnt_reg <= '0;
         flash_reg <= ~flash_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         snd_cnt_reg <= '0;
         pulse_reg <= 1'b0;
      end else if (snd_cnt_reg == 32'(SND_CYC - 1)) begin
         snd_cnt_reg <= '0;
         pulse_reg <= ~pulse_reg;
      end else begin
         snd_cnt_reg <= snd_cnt_reg + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Switch inputs
   // ----------------------------------------------------------------
   logic [NUM_SW-1:0] raw;
   logic [NUM_SW-1:0] sync1_reg;
   logic [NUM_SW-1:0] sync2_reg;
   logic [NUM_SW-1:0] stable_reg;
   logic [NUM_SW-1:0] active_reg;
   logic [31:0] deb_cnt_reg [NUM_SW];

   // Either connector closing input eight pulls its level high
   assign raw = {sw_pin_i[NUM_SW-1] | sw8_aux_pin_i,
                 sw_pin_i[NUM_SW-2:0]};

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw;
         sync2_reg <= sync1_reg;
      end
   end

   // Debounce restarts whenever the input agrees with the stable level
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         stable_reg <= '0;
         for (int i = 0; i < NUM_SW; i++) begin
            deb_cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_SW; i++) begin
            if (sync2_reg[i] == stable_reg[i]) begin
               deb_cnt_reg[i] <= '0;
            end else if (deb_cnt_reg[i] == 32'(DEB_CYC - 1)) begin
               deb_cnt_reg[i] <= '0;
               stable_reg[i] <= sync2_reg[i];
            end else begin
               deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h1;
            end
         end
      end
   end

   logic [NUM_SW-1:0] active_now;
   // Closure reads as one; active-low inverts
   assign active_now = ~(stable_reg ^ pol_reg);

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         active_reg <= '0;
         sw_action_o <= '0;
      end else begin
         active_reg <= active_now;
         sw_action_o <= active_now & ~active_reg & act_en_reg;
      end
   end

   // ----------------------------------------------------------------
   // Latched conditions and acknowledge
   // ----------------------------------------------------------------
   logic ack;
   logic alarm_lat_reg;
   logic supv_lat_reg;
   logic silenced_reg;
   logic alarm_d_reg;
   logic [4:0] unack_reg;
   logic [4:0] src;
   logic [4:0] src_d_reg;
   logic trouble_any;

   assign ack = cmd[K_ACK];
   assign trouble_any = cond_reg[C_TROUBLE] | cond_reg[C_NOTIF_FAULT];

   // Alarm holds until panel reset; a new alarm wins over reset
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         alarm_lat_reg <= 1'b0;
         supv_lat_reg <= 1'b0;
      end else begin
         if (cond_reg[C_ALARM]) begin
            alarm_lat_reg <= 1'b1;
         end else if (cmd[K_RESET]) begin
            alarm_lat_reg <= 1'b0;
         end
         if (cond_reg[C_SUPV] & cond_reg[C_SUPV_LATCH]) begin
            supv_lat_reg <= 1'b1;
         end else if (cmd[K_RESET]) begin
            supv_lat_reg <= 1'b0;
         end
      end
   end

   // Sources: alarm, pre-alarm, supervisory, circuit fault, trouble
   assign src = {trouble_any, cond_reg[C_NOTIF_FAULT],
                 cond_reg[C_SUPV] | supv_lat_reg,
                 cond_reg[C_PREALARM] & ~cond_reg[C_ALARM],
                 alarm_lat_reg};

   // New onset sets unacknowledged; onset wins over ack
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         src_d_reg <= '0;
         unack_reg <= '0;
         alarm_d_reg <= 1'b0;
      end else begin
         src_d_reg <= src;
         alarm_d_reg <= cond_reg[C_ALARM];
         for (int i = 0; i < 5; i++) begin
            if (src[i] & ~src_d_reg[i]) begin
               unack_reg[i] <= 1'b1;
            end else if (ack | ~src[i]) begin
               unack_reg[i] <= 1'b0;
            end
         end
         if (i_alarm_rise()) begin
            unack_reg[0] <= 1'b1;
         end
      end
   end

   function automatic logic i_alarm_rise();
      return cond_reg[C_ALARM] & ~alarm_d_reg;
   endfunction : i_alarm_rise

   // Silence set by key; new alarm or resound clears it
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         silenced_reg <= 1'b0;
      end else if (cmd[K_RESOUND] | i_alarm_rise() | cmd[K_RESET]) begin
         silenced_reg <= 1'b0;
      end else if (cmd[K_SILENCE] & alarm_lat_reg) begin
         silenced_reg <= 1'b1;
      end
   end

   function automatic logic show(input logic on, input logic blink);
      return on & (~blink | flash_reg);
   endfunction : show

   // ----------------------------------------------------------------
   // Indicator outputs
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         led_o <= '0;
         sounder_o <= 1'b0;
      end else begin
         led_o[L_ALARM] <= show(src[0], unack_reg[0]);
         led_o[L_PREALARM] <= show(src[1], unack_reg[1]);
         led_o[L_DISABLE] <= cond_reg[C_DISABLED];
         led_o[L_TEST] <= cond_reg[C_TEST];
         led_o[L_PAS] <= cond_reg[C_PAS];
         led_o[L_POWER] <= show(1'b1, ~cond_reg[C_MAINS]);
         led_o[L_SUPV] <= show(src[2], unack_reg[2]);
         led_o[L_SILENCED] <= silenced_reg;
         led_o[L_NFAULT] <= show(src[3], unack_reg[3]);
         led_o[L_NDIS] <= cond_reg[C_NOTIF_DIS];
         led_o[L_TROUBLE] <= show(src[4], unack_reg[4]);
         led_o[L_PROG] <= cond_reg[C_PROG];
         // Sounder quiet once everything is acknowledged
         if (|unack_reg[1:0]) begin
            sounder_o <= 1'b1;
         end else begin
            sounder_o <= (|unack_reg[4:2]) & pulse_reg;
         end
      end
   end

   // Configurable indicators; switch mode mirrors the matching input
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         func_led_o <= '0;
      end else begin
         for (int i = 0; i < NUM_FN; i++) begin
            case (func_mode_e'(func_reg[2*i +: 2]))
               FN_OFF: func_led_o[i] <= 1'b0;
               FN_ON: func_led_o[i] <= 1'b1;
               FN_FLASH: func_led_o[i] <= flash_reg;
               FN_SWITCH: func_led_o[i] <= active_reg[i];
               default: func_led_o[i] <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= '0;
      end else if (psel_i & ~penable_i & ~pwrite_i) begin
         case (paddr_i)
            COND_OFS: prdata_o <= 32'(cond_reg);
            POL_OFS: prdata_o <= 32'(pol_reg);
            SWST_OFS: prdata_o <= {16'h0000, 8'(stable_reg), 8'(active_reg)};
            FUNC_OFS: prdata_o <= 32'(func_reg);
            LED_OFS: prdata_o <= {14'h0000, 6'(func_led_o), led_o};
            ACT_OFS: prdata_o <= 32'(act_en_reg);
            default: prdata_o <= '0;
         endcase
      end
   end

   logic unused_rd;
   assign unused_rd = rd_en;

endmodule : panel_status_indicator_logic

`default_nettype wire

// ---- tb/panel_ind_monitor.sv ----
/*
 Checker for the panel indicator block, bound to its top-level ports.
 Assumes a zero-wait APB master and a single synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_ind_monitor
   import panel_ind_pkg::*;
#(
   parameter int FLASH_CYC = 4
) (
   // Clock, reset and bus
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Indicators and actions
   input wire logic [LED_W-1:0] led_o,
   input wire logic [5:0] func_led_o,
   input wire logic [7:0] sw_action_o
);
   // ----------------------------------------------------------------
   // Shadow registers
   // ----------------------------------------------------------------
   logic wr;
   logic [11:0] cond_reg;
   logic [7:0] act_reg;
   logic [3:0] since_reg;
   int run_reg;
   assign wr = psel_i && penable_i && pready_o && pwrite_i;
   // Settle counter, so checks skip the registering edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cond_reg <= 12'h000;
         since_reg <= 4'h0;
      end else if (wr && paddr_i == COND_OFS) begin
         cond_reg <= pwdata_i[11:0];
         since_reg <= 4'h0;
      end else if (since_reg != 4'hf) begin
         since_reg <= since_reg + 4'h1;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         act_reg <= ACT_RST;
      end else if (wr && paddr_i == ACT_OFS) begin
         act_reg <= pwdata_i[7:0];
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !led_o[L_POWER]) begin
         run_reg <= 0;
      end else begin
         run_reg <= run_reg + 1;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_ready_high: assert property (pready_o)
      else $error("pready low");
   a_bad_addr: assert property (psel_i && penable_i && paddr_i[1:0] == 2'b00
      |-> pslverr_o == (paddr_i > ACT_OFS)) else $error("pslverr wrong");
   a_dark_reset: assert property ($fell(sys_rst_i) |->
      led_o == 12'h000 && func_led_o == 6'h00) else $error("lit at reset");
   a_steady_levels: assert property (since_reg >= 4'h3 |->
      led_o[L_DISABLE] == cond_reg[C_DISABLED] &&
      led_o[L_TEST] == cond_reg[C_TEST] && led_o[L_PAS] == cond_reg[C_PAS] &&
      led_o[L_NDIS] == cond_reg[C_NOTIF_DIS] &&
      led_o[L_PROG] == cond_reg[C_PROG]) else $error("level led wrong");
   a_power_on: assert property (since_reg >= 4'h3 && cond_reg[C_MAINS]
      |-> led_o[L_POWER]) else $error("power not steady");
   a_flash_half: assert property ($fell(led_o[L_POWER]) &&
      since_reg == 4'hf && !cond_reg[C_MAINS] |-> run_reg == FLASH_CYC)
      else $error("flash half period wrong");
   a_prealarm_off: assert property (since_reg >= 4'h3 &&
      cond_reg[C_ALARM] |-> !led_o[L_PREALARM]) else $error("prealarm lit");
   a_fault_trouble: assert property (since_reg >= 4'h3 &&
      led_o[L_NFAULT] |-> led_o[L_TROUBLE]) else $error("trouble not lit");
   a_action_pulse: assert property (
      (sw_action_o & $past(sw_action_o)) == 8'h00) else $error("long pulse");
   a_action_enable: assert property (
      (sw_action_o & ~$past(act_reg)) == 8'h00)
      else $error("action not enabled");
endmodule : panel_ind_monitor
bind panel_status_indicator_logic panel_ind_monitor #(
   .FLASH_CYC(FLASH_CYC)
) u_mon (
   .ref_clk_i(ref_clk_i),
   .sys_rst_i(sys_rst_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .pwdata_i(pwdata_i),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .led_o(led_o),
   .func_led_o(func_led_o),
   .sw_action_o(sw_action_o)
);
`default_nettype wire

// ---- tb/contact_bank_model.sv ----
/*
 Contact model: eight inputs plus the second connector of input eight.
 Assumes commanded levels, 1 = closed; every change chatters first.
*/
`timescale 1ns/1ps
`default_nettype none
module contact_bank_model #(
   parameter int BOUNCE = 4
) (
   // Clock and commanded contacts
   input wire logic clk_i,
   input wire logic [7:0] closed_i,
   input wire logic aux_closed_i,
   // Pins
   output logic [7:0] sw_pin_o,
   output logic aux_pin_o
);
   logic [8:0] cur;
   logic [8:0] last_reg = 9'h000;
   logic [8:0] chg_reg = 9'h000;
   int cnt_reg = 0;
   assign cur = {aux_closed_i, closed_i};
   // Real contacts bounce; glitches of one cycle each
   always_ff @(posedge clk_i) begin
      last_reg <= cur;
      if (cur != last_reg) begin
         chg_reg <= cur ^ last_reg;
         cnt_reg <= BOUNCE;
      end else if (cnt_reg != 0) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
   assign {aux_pin_o, sw_pin_o} = cnt_reg[0] ? cur ^ chg_reg : cur;
endmodule : contact_bank_model
`default_nettype wire

// ---- tb/test_panel_status_indicator_logic.sv ----
/*
 Self-checking bench: APB tasks, indicator sampling, contact model.
 Assumes short test counts set through the design parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module test_panel_status_indicator_logic;
   import panel_ind_pkg::*;
   localparam logic [31:0] M = 1 << C_MAINS;
   localparam logic [31:0] A = 1 << C_ALARM;
   localparam logic [31:0] S = 1 << C_SUPV;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, aux_closed = 1'b0;
   logic [7:0] paddr = 8'h00, closed = 8'h00, sw_pin, act;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, snd, aux_pin;
   logic [11:0] led;
   logic [5:0] fled;
   logic [18:0] view;
   int n_fail = 0, n_checks = 0;
   int pulses [8];
   assign view = {snd, fled, led};
   always #20 clk = ~clk;
   panel_status_indicator_logic #(.FLASH_CYC(4), .DEB_CYC(3), .SND_CYC(6))
   uut (.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sw_pin_i(sw_pin), .sw8_aux_pin_i(aux_pin),
      .led_o(led), .func_led_o(fled), .sounder_o(snd), .sw_action_o(act));
   contact_bank_model #(.BOUNCE(4)) u_contacts (.clk_i(clk),
      .closed_i(closed), .aux_closed_i(aux_closed), .sw_pin_o(sw_pin),
      .aux_pin_o(aux_pin));
   always @(posedge clk) begin
      for (int i = 0; i < 8; i++) if (act[i] === 1'b1) pulses[i]++;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task results;
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      repeat (2) @(posedge clk);
   endtask : wr
   // Unmapped places must answer with an error and zero
   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, a > ACT_OFS});
   endtask : rd
   // Class of a view bit over 16 cycles: 0 dark, 1 steady, 2 flashing
   task obs(input int idx, input int mode);
      int hi, lo;
      hi = 0;
      lo = 0;
      repeat (2) @(posedge clk);
      repeat (16) begin
         @(posedge clk);
         if (view[idx] === 1'b1) hi++;
         if (view[idx] === 1'b0) lo++;
      end
      chk(hi + lo != 16 ? 3 : hi == 0 ? 0 : hi == 16 ? 1 : 2, mode);
   endtask : obs
   task cyc(input logic [31:0] c, input int l, input int s);
      wr(COND_OFS, M | c);
      obs(l, 2);
      obs(18, s);
      wr(CMD_OFS, 1 << K_ACK);
      obs(l, 1);
      wr(COND_OFS, M);
      obs(l, 0);
   endtask : cyc
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(POL_OFS, 32'hff);
      rd(SWST_OFS, 32'h0);
      rd(FUNC_OFS, 32'h0);
      for (int i = 12; i < 18; i++) obs(i, 0);
      rd(8'h1c, 32'h0);
      wr(COND_OFS, M | 1 << C_DISABLED | 1 << C_TEST | 1 << C_PAS |
         1 << C_NOTIF_DIS | 1 << C_PROG);
      rd(LED_OFS, 1 << L_POWER | 1 << L_DISABLE | 1 << L_TEST | 1 << L_PAS |
         1 << L_NDIS | 1 << L_PROG);
      wr(COND_OFS, M);
      rd(LED_OFS, 1 << L_POWER);
      wr(COND_OFS, 32'h0);
      obs(L_POWER, 2);
      wr(COND_OFS, M | A);
      obs(L_ALARM, 2);
      obs(18, 1);
      wr(CMD_OFS, 1 << K_ACK);
      obs(L_ALARM, 1);
      wr(CMD_OFS, 1 << K_SILENCE);
      obs(L_SILENCED, 1);
      wr(CMD_OFS, 1 << K_RESOUND);
      obs(L_SILENCED, 0);
      wr(CMD_OFS, 1 << K_SILENCE);
      wr(COND_OFS, M);
      obs(L_ALARM, 1);
      wr(COND_OFS, M | A);
      obs(L_SILENCED, 0);
      wr(COND_OFS, M);
      wr(CMD_OFS, 1 << K_RESET);
      obs(L_ALARM, 0);
      cyc(1 << C_PREALARM, L_PREALARM, 1);
      cyc(S, L_SUPV, 2);
      cyc(1 << C_NOTIF_FAULT, L_NFAULT, 2);
      cyc(1 << C_NOTIF_FAULT, L_TROUBLE, 2);
      cyc(1 << C_TROUBLE, L_TROUBLE, 2);
      wr(COND_OFS, M | 1 << C_PREALARM);
      wr(COND_OFS, M | A);
      obs(L_PREALARM, 0);
      wr(COND_OFS, M | S | 1 << C_TROUBLE);
      wr(CMD_OFS, 1 << K_ACK);
      obs(L_SUPV, 1);
      obs(L_TROUBLE, 1);
      wr(COND_OFS, M | S | 1 << C_SUPV_LATCH);
      wr(COND_OFS, M);
      wr(CMD_OFS, 1 << K_RESET);
      wr(COND_OFS, M | S | 1 << C_SUPV_LATCH);
      wr(COND_OFS, M);
      obs(L_SUPV, 2);
      wr(CMD_OFS, 1 << K_RESET);
      obs(L_SUPV, 0);
      // Configurable leds: on, flash, follow input 2, rest off
      wr(FUNC_OFS, 32'h39);
      rd(FUNC_OFS, 32'h39);
      obs(12, 1);
      obs(13, 2);
      obs(14, 0);
      wr(ACT_OFS, 32'hfe);
      closed <= 8'h04;
      // Chatter, two sync stages and debounce take about a dozen cycles
      repeat (12) @(posedge clk);
      obs(14, 1);
      rd(SWST_OFS, 32'h0404);
      wr(POL_OFS, 32'hdf);
      obs(15, 0);
      rd(SWST_OFS, 32'h0424);
      aux_closed <= 1'b1;
      obs(14, 1);
      rd(SWST_OFS, 32'h84a4);
      closed <= 8'h05;
      obs(14, 1);
      rd(SWST_OFS, 32'h85a5);
      chk(pulses[2], 1);
      chk(pulses[5], 1);
      chk(pulses[7], 1);
      chk(pulses[0], 0);
      results();
   end
   initial begin
      #1000000;
      n_fail++;
      results();
   end
endmodule : test_panel_status_indicator_logic
`default_nettype wire
